// *** hdl/ocr_divider.sv ***
// ocr_divider: output 6 post divider working on sampled source levels.
// assumes src_i is a level synchronous to ref_clk_i, slower than half rate.
`timescale 1ns/1ps

module ocr_divider (
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      arst_n_i,
  // divider setting
  input  wire logic [1:0]                div_sel_i,
  input  wire logic [ocr_pkg::DIV_W-1:0] div_val_i,
  // source level and divided level
  input  wire logic                      src_i,
  output logic                           div_o
);
  import ocr_pkg::*;

  logic             src_reg;
  logic             src_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             div_reg;
  logic             div_next;
  logic             rise;
  logic [CNT_W-1:0] period;

  // period in source edges for the programmed mode
  always_comb begin
    period = CNT_W'(div_val_i) + DIV_VAL_OFFSET;
    rise   = src_i & ~src_reg;
  end

  // next state per divide select
  always_comb begin
    src_next = src_i;
    cnt_next = cnt_reg;
    div_next = div_reg;
    unique case (div_sel_i)
      DIV_SEL_OFF: begin
        cnt_next = '0;
        div_next = 1'b0;
      end
      DIV_SEL_BY1: begin
        cnt_next = '0;
        div_next = src_i;
      end
      DIV_SEL_BY2: begin
        cnt_next = '0;
        if (rise) begin
          div_next = ~div_reg;
        end
      end
      DIV_SEL_BYVAL: begin
        if (rise) begin
          if (cnt_reg >= period - 11'h001) begin
            cnt_next = '0;
          end else begin
            cnt_next = cnt_reg + 11'h001;
          end
        end
        div_next = (cnt_next < (period >> 1)); // high for first half
      end
    endcase
  end

  // register divider state
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_reg <= 1'b0;
      cnt_reg <= '0;
      div_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
    end
  end

  assign div_o = div_reg;

  // disabled divider holds low
  chk_div_off_low: assert property ( // RQ6
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    div_sel_i == DIV_SEL_OFF |=> !div_reg)
    else $error("divider output not low while disabled");

endmodule // ocr_divider

// *** hdl/ocr_out6_regs.sv ***
// ocr_out6_regs: output 6 configuration registers and output stage.
// assumes a byte write/read port from the serial programming logic,
// all inputs synchronous to ref_clk_i.
//
// Overview of operation
// (RQ1) differential output 5 needs edge rate code 00
// (RQ2) polarity bit 0 passes, 1 inverts output 6
// (RQ3) edge rate code picks one of four slews
// (RQ4) disabled output tri-states, parks low or high
// (RQ5) two divider values, reset to 2
// (RQ6) divide select: off, by 1, by 2, value+2
// (RQ7) both divide selects non-zero to enable
`timescale 1ns/1ps

module ocr_out6_regs (
  // clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       arst_n_i,
  // register write port
  input  wire logic                       wr_en_i,
  input  wire logic [ocr_pkg::ADDR_W-1:0] wr_addr_i,
  input  wire logic [ocr_pkg::REG_W-1:0]  wr_data_i,
  // register read port
  input  wire logic [ocr_pkg::ADDR_W-1:0] rd_addr_i,
  output logic      [ocr_pkg::REG_W-1:0]  rd_data_o,
  output logic                            rd_hit_o,
  // configuration selection and upper divider bits from neighbours
  input  wire logic                       multi_config_operation_i,
  input  wire logic                       second_config_set_i,
  input  wire logic [ocr_pkg::REG_W-1:0]  out6_div_hi_c0_i,
  input  wire logic [ocr_pkg::REG_W-1:0]  out6_div_hi_c1_i,
  // enable controls
  input  wire logic                       out6_enable_bit_i,
  input  wire logic                       shutdown_enable_pin_i,
  // clock source for output 6
  input  wire logic                       out6_src_i,
  // output pad and settings
  output logic                            out6_pad_o,
  output logic                            out6_pad_oe_o,
  output logic      [1:0]                 out6_edge_rate_code_o,
  output logic      [ocr_pkg::REG_W-1:0]  out5_divider_value_hi_alt_o
);
  import ocr_pkg::*;

  // register storage
  logic [REG_W-1:0] out5_div_hi_alt_reg;
  logic [REG_W-1:0] out5_div_hi_alt_next;
  logic [REG_W-1:0] drive_reg;
  logic [REG_W-1:0] drive_next;
  logic [REG_W-1:0] div_lo_reg;
  logic [REG_W-1:0] div_lo_next;
  logic [REG_W-1:0] rd_data_reg;
  logic [REG_W-1:0] rd_data_next;
  logic             rd_hit_reg;
  logic             rd_hit_next;

  // output stage state
  logic             pad_reg;
  logic             pad_next;
  logic             pad_oe_reg;
  logic             pad_oe_next;

  // decoded fields
  logic [1:0]       out6_disable_state_mode;
  logic             out6_polarity_flip;
  logic [1:0]       sel_c0;
  logic [1:0]       sel_c1;
  logic [DIV_W-1:0] val_c0;
  logic [DIV_W-1:0] val_c1;
  logic             use_c1;
  logic [1:0]       out6_divide_select;
  logic [DIV_W-1:0] out6_divider_value;
  logic             out6_active;
  logic             div_level;

  // address match against one offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        off);
    addr_is = (a == off);
  endfunction

  // register writes; every bit is read/write
  always_comb begin
    out5_div_hi_alt_next = out5_div_hi_alt_reg;
    drive_next           = drive_reg;
    div_lo_next          = div_lo_reg;
    if (wr_en_i) begin
      if (addr_is(wr_addr_i, OFF_OUT5_DIV_HI_ALT)) begin
        out5_div_hi_alt_next = wr_data_i;
      end
      if (addr_is(wr_addr_i, OFF_OUT6_DRIVE)) begin
        drive_next = wr_data_i;
      end
      if (addr_is(wr_addr_i, OFF_OUT6_DIV_LO)) begin
        div_lo_next = wr_data_i;
      end
    end
  end

  // register read mux; unmapped offsets read zero with no hit
  always_comb begin
    rd_data_next = '0;
    rd_hit_next  = 1'b1;
    if (addr_is(rd_addr_i, OFF_OUT5_DIV_HI_ALT)) begin
      rd_data_next = out5_div_hi_alt_reg;
    end else if (addr_is(rd_addr_i, OFF_OUT6_DRIVE)) begin
      rd_data_next = drive_reg;
    end else if (addr_is(rd_addr_i, OFF_OUT6_DIV_LO)) begin
      rd_data_next = div_lo_reg;
    end else begin
      rd_hit_next = 1'b0;
    end
  end

  // register file flops
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out5_div_hi_alt_reg <= RST_OUT5_DIV_HI_ALT;
      drive_reg           <= RST_OUT6_DRIVE;
      div_lo_reg          <= RST_OUT6_DIV_LO; // RQ5
      rd_data_reg         <= '0;
      rd_hit_reg          <= 1'b0;
    end else begin
      out5_div_hi_alt_reg <= out5_div_hi_alt_next;
      drive_reg           <= drive_next;
      div_lo_reg          <= div_lo_next;
      rd_data_reg         <= rd_data_next;
      rd_hit_reg          <= rd_hit_next;
    end
  end

  // field extraction and configuration choice
  always_comb begin
    out6_disable_state_mode = drive_reg[POS_DISABLE_MODE +: 2];
    out6_polarity_flip      = drive_reg[POS_POLARITY];
    sel_c0 = div_lo_reg[POS_DIV_SEL_C0 +: 2];
    sel_c1 = div_lo_reg[POS_DIV_SEL_C1 +: 2];
    val_c0 = {out6_div_hi_c0_i, div_lo_reg[POS_DIV_VAL_C0 +: 2]}; // RQ5
    val_c1 = {out6_div_hi_c1_i, div_lo_reg[POS_DIV_VAL_C1 +: 2]}; // RQ5
    use_c1 = multi_config_operation_i & second_config_set_i;
    out6_divide_select = use_c1 ? sel_c1 : sel_c0;
    out6_divider_value = use_c1 ? val_c1 : val_c0;
    // output runs only with both selects set and enables true
    out6_active = out6_enable_bit_i & shutdown_enable_pin_i
                & (sel_c0 != DIV_SEL_OFF) & (sel_c1 != DIV_SEL_OFF); // RQ7
  end

  // post divider
  ocr_divider ocr_divider_inst (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .div_sel_i (out6_divide_select), // RQ6
    .div_val_i (out6_divider_value),
    .src_i     (out6_src_i),
    .div_o     (div_level)
  );

  // pad level and enable: polarity when running, park or float per mode when disabled
  always_comb begin
    pad_next    = div_level ^ out6_polarity_flip; // RQ2
    pad_oe_next = 1'b1;
    if (!out6_active) begin
      unique case (out6_disable_state_mode) // RQ4
        DIS_PARK_LOW: begin
          pad_next = 1'b0;
        end
        DIS_PARK_HIGH: begin
          pad_next = 1'b1;
        end
        default: begin
          pad_next    = 1'b0;
          pad_oe_next = 1'b0;
        end
      endcase
    end
  end

  // output stage flops
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pad_reg    <= 1'b0;
      pad_oe_reg <= 1'b0;
    end else begin
      pad_reg    <= pad_next;
      pad_oe_reg <= pad_oe_next;
    end
  end

  // outputs straight from flops
  assign out6_pad_o                  = pad_reg;
  assign out6_pad_oe_o               = pad_oe_reg;
  assign out6_edge_rate_code_o       = drive_reg[POS_EDGE_RATE +: 2]; // RQ3
  assign out5_divider_value_hi_alt_o = out5_div_hi_alt_reg;
  assign rd_data_o                   = rd_data_reg;
  assign rd_hit_o                    = rd_hit_reg;

  // running output follows divider level xor polarity
  chk_pad_polarity: assert property ( // RQ2
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    out6_active
    |=> out6_pad_o == ($past(div_level) ^ $past(out6_polarity_flip)))
    else $error("pad level does not follow polarity");

  // edge rate code reflects written value one cycle after write
  chk_edge_rate_wr: assert property ( // RQ3
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_en_i && wr_addr_i == OFF_OUT6_DRIVE
    |=> out6_edge_rate_code_o == $past(wr_data_i[POS_EDGE_RATE +: 2]))
    else $error("edge rate code not updated by write");

  // disabled output parks or floats per mode
  chk_disable_state: assert property ( // RQ4
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !out6_active |=> (out6_pad_oe_o == $past(out6_disable_state_mode[1]))
      && (!out6_pad_oe_o || out6_pad_o == $past(out6_disable_state_mode[0])))
    else $error("disabled output state wrong");

  // a zero divide select in either set floats the pad in tri-state modes
  chk_both_sel_needed: assert property ( // RQ7
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (sel_c0 == DIV_SEL_OFF || sel_c1 == DIV_SEL_OFF) && !drive_reg[7]
    |=> !out6_pad_oe_o)
    else $error("output enabled with a zero divide select");

  // read returns the stored divider register
  chk_read_div_lo: assert property ( // RQ5
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    rd_addr_i == OFF_OUT6_DIV_LO
    |=> rd_data_o == $past(div_lo_reg) && rd_hit_o)
    else $error("divider register read mismatch");

  cov_running: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    out6_active && out6_polarity_flip);
  cov_park_high: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !out6_active && out6_disable_state_mode == DIS_PARK_HIGH);
  cov_second_set: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    use_c1 && out6_active);

endmodule // ocr_out6_regs

// *** hdl/ocr_pkg.sv ***
// ocr_pkg: register map, field layout and reset values for the output 6
// configuration slice; shared by the register bank and its divider.
package ocr_pkg;

  // register data and address width
  localparam int REG_W  = 8;
  localparam int ADDR_W = 8;
  // full divider value width and counter width
  localparam int DIV_W  = 10;
  localparam int CNT_W  = 11;

  // register offsets
  localparam logic [7:0] OFF_OUT5_DIV_HI_ALT = 8'h5B;
  localparam logic [7:0] OFF_OUT6_DRIVE      = 8'h5C;
  localparam logic [7:0] OFF_OUT6_DIV_LO     = 8'h5D;

  // reset values
  localparam logic [7:0] RST_OUT5_DIV_HI_ALT = 8'h00;
  localparam logic [7:0] RST_OUT6_DRIVE      = 8'h03;
  localparam logic [7:0] RST_OUT6_DIV_LO     = 8'hBB;

  // drive control field positions (low bit of each field)
  localparam int POS_DISABLE_MODE = 6;
  localparam int POS_EDGE_RATE    = 4;
  localparam int POS_POLARITY     = 2;

  // divider register field positions (low bit of each field)
  localparam int POS_DIV_VAL_C1 = 6;
  localparam int POS_DIV_SEL_C1 = 4;
  localparam int POS_DIV_VAL_C0 = 2;
  localparam int POS_DIV_SEL_C0 = 0;

  // divide-select codes
  localparam logic [1:0] DIV_SEL_OFF   = 2'h0;
  localparam logic [1:0] DIV_SEL_BY1   = 2'h1;
  localparam logic [1:0] DIV_SEL_BY2   = 2'h2;
  localparam logic [1:0] DIV_SEL_BYVAL = 2'h3;

  // divider value offset added in programmed mode
  localparam logic [CNT_W-1:0] DIV_VAL_OFFSET = 11'h002;

  // disabled-state codes (upper bit clear means tri-state)
  localparam logic [1:0] DIS_PARK_LOW  = 2'h2;
  localparam logic [1:0] DIS_PARK_HIGH = 2'h3;

endpackage : ocr_pkg

// *** tb/ocr_out6_regs_tb.sv ***
// ocr_out6_regs_tb: self-checking bench for the output 6 register slice.
// assumes the design's own assertions sit inside its files; no checker.
`timescale 1ns/1ps

module ocr_out6_regs_tb;
  import ocr_pkg::*;

  logic              ref_clk_i, arst_n_i, wr_en_i, multi_config_operation, set2;
  logic [ADDR_W-1:0] wr_addr_i, rd_addr_i;
  logic [REG_W-1:0]  wr_data_i, rd_data_o, hi_c0, hi_c1, out5_hi;
  logic              rd_hit_o, en_bit, pin, src, pad, oe, run;
  logic              src_ph, src_lvl, pad_prev;
  logic [1:0]        edge_code;
  int                mismatches, checks_done, rises;

  ocr_out6_regs ocr_out6_regs_inst (
    .ref_clk_i                   (ref_clk_i),
    .arst_n_i                    (arst_n_i),
    .wr_en_i                     (wr_en_i),
    .wr_addr_i                   (wr_addr_i),
    .wr_data_i                   (wr_data_i),
    .rd_addr_i                   (rd_addr_i),
    .rd_data_o                   (rd_data_o),
    .rd_hit_o                    (rd_hit_o),
    .multi_config_operation_i    (multi_config_operation),
    .second_config_set_i         (set2),
    .out6_div_hi_c0_i            (hi_c0),
    .out6_div_hi_c1_i            (hi_c1),
    .out6_enable_bit_i           (en_bit),
    .shutdown_enable_pin_i       (pin),
    .out6_src_i                  (src),
    .out6_pad_o                  (pad),
    .out6_pad_oe_o               (oe),
    .out6_edge_rate_code_o       (edge_code),
    .out5_divider_value_hi_alt_o (out5_hi)
  );

  // clock, 5 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // source clock: toggles every two cycles while run is set, else follows src_lvl
  always @(posedge ref_clk_i) begin
    if (run) begin
      src_ph <= ~src_ph;
      if (src_ph) begin
        src <= ~src;
      end
    end else begin
      src_ph <= 1'b0;
      src    <= src_lvl;
    end
  end

  // count driven pad rising edges while the source runs
  always @(posedge ref_clk_i) begin
    pad_prev <= pad;
    if (!run) begin
      rises <= 0;
    end else if (oe && pad && !pad_prev) begin
      rises <= rises + 1;
    end
  end

  task automatic check(input logic [7:0] seen, exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk_i);
    wr_en_i   <= 1'b1;
    wr_addr_i <= a;
    wr_data_i <= d;
    @(posedge ref_clk_i);
    wr_en_i   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, exp, input logic hit);
    @(posedge ref_clk_i);
    rd_addr_i <= a;
    @(posedge ref_clk_i);
    #1;
    check(rd_data_o, exp, "read data");
    check({7'h00, rd_hit_o}, {7'h00, hit}, "read hit");
  endtask

  task automatic settle();
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask

  // reset values, unmapped read
  task automatic t_reset();
    rd(8'h5B, 8'h00, 1'b1);
    rd(8'h5C, 8'h03, 1'b1);
    rd(8'h5D, 8'hBB, 1'b1);
    rd(8'h5E, 8'h00, 1'b0);
    check({6'h00, edge_code}, 8'h00, "edge reset");
  endtask

  // every edge-rate code and the output 5 upper divider byte
  task automatic t_edge();
    for (int c = 0; c < 4; c++) begin
      wr(8'h5C, 8'h03 | 8'(c << 4));
      settle();
      check({6'h00, edge_code}, 8'(c), "edge code");
      rd(8'h5C, 8'h03 | 8'(c << 4), 1'b1);
    end
    // output 5 edge rate lives outside this slice; only its divider byte
    wr(8'h5B, 8'hA5);
    wr(8'h71, 8'hFF);
    settle();
    check(out5_hi, 8'hA5, "out5 upper");
    rd(8'h5B, 8'hA5, 1'b1);
  endtask

  // disabled-state codes by enable bit and by pin
  task automatic t_disable();
    logic [7:0] exp [4] = '{8'h00, 8'h00, 8'h02, 8'h03};
    wr(8'h5D, 8'h11);
    for (int m = 0; m < 8; m++) begin
      wr(8'h5C, {m[1:0], 6'h03});
      en_bit <= m[2];
      pin    <= ~m[2];
      settle();
      check({6'h00, oe, oe & pad}, exp[m[1:0]], "disabled pad");
    end
    en_bit <= 1'b1;
    pin    <= 1'b1;
  endtask

  // polarity with divide by one on a held source
  task automatic t_polarity();
    for (int k = 0; k < 4; k++) begin
      src_lvl <= k[0];
      wr(8'h5C, {5'h00, k[1], 2'h3});
      settle();
      check({6'h00, oe, pad}, {6'h00, 1'b1, k[0] ^ k[1]}, "polarity");
    end
    wr(8'h5D, 8'h10);
    settle();
    check({7'h00, oe}, 8'h00, "sel zero off");
  endtask

  // count pad rises over 32 source rises
  task automatic count(input logic [7:0] cfg, input int exp);
    logic near;
    wr(8'h5D, cfg);
    settle();
    run <= 1'b1;
    repeat (128) @(posedge ref_clk_i);
    run <= 1'b0;
    #1;
    near = (rises >= exp - 1) && (rises <= exp + 1);
    check({7'h00, near}, 8'h01, "rises");
  endtask

  // divide modes and configuration selection
  task automatic t_divide();
    wr(8'h5C, 8'h03);
    count(8'h11, 32);
    count(8'h22, 16);
    count(8'h3B, 8);
    multi_config_operation  <= 1'b1;
    set2 <= 1'b1;
    count(8'h3B, 16);
    hi_c1 <= 8'h01;
    count(8'h3B, 5);
    multi_config_operation   <= 1'b0;
    hi_c0 <= 8'h03;
    count(8'h3B, 2);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #200us;
    mismatches++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    {arst_n_i, wr_en_i, multi_config_operation, set2, run, en_bit, pin, src_lvl} = 8'h06;
    {wr_addr_i, rd_addr_i, wr_data_i, hi_c0, hi_c1} = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_edge();
    t_disable();
    t_polarity();
    t_divide();
    tally_and_finish();
  end
endmodule // ocr_out6_regs_tb
